// ==== logic/nmc_pkg.sv ====
// Constants for the numeric move command register bank
package nmc_pkg;
  // Register word addresses
  localparam logic [15:0] NMC_ADDR_TARGET_HI = 16'h9900;
  localparam logic [15:0] NMC_ADDR_TARGET_LO = 16'h9901;
  localparam logic [15:0] NMC_ADDR_BAND_HI = 16'h9902;
  localparam logic [15:0] NMC_ADDR_BAND_LO = 16'h9903;
  localparam logic [15:0] NMC_ADDR_SPEED_HI = 16'h9904;
  localparam logic [15:0] NMC_ADDR_SPEED_LO = 16'h9905;
  localparam logic [15:0] NMC_ADDR_ACCEL = 16'h9906;
  localparam logic [15:0] NMC_ADDR_PUSH = 16'h9907;
  localparam logic [15:0] NMC_ADDR_FLAGS = 16'h9908;
  // Value ranges
  localparam logic [31:0] NMC_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] NMC_SPEED_MAX = 32'h000f_423f;
  localparam logic [15:0] NMC_ACCEL_MIN = 16'h0001;
  localparam logic [15:0] NMC_ACCEL_MAX = 16'h012c;
  localparam logic [31:0] NMC_BAND_DEFAULT = 32'h0000_000a;
  // Reset values
  localparam logic [31:0] NMC_RST_TARGET = 32'h0000_0000;
  localparam logic [15:0] NMC_RST_PUSH = 16'h0000;
  localparam logic [15:0] NMC_RST_FLAGS = 16'h0000;
  // Control flag fields
  localparam int NMC_F_PUSH = 1;
  localparam int NMC_F_DIR = 2;
  localparam int NMC_F_INC = 3;
  localparam int NMC_F_GAIN = 4;
  localparam int NMC_F_PROF = 6;
  localparam int NMC_F_VIB = 12;
  localparam logic [15:0] NMC_FLAGS_MASK = 16'h30fe;
  // Acceleration profile codes
  typedef enum logic [1:0] {
    NMC_PROF_TRAP = 2'h0,
    NMC_PROF_SCURVE = 2'h1,
    NMC_PROF_DELAY = 2'h2,
    NMC_PROF_BAD = 2'h3
  } nmc_prof_e;
endpackage

// ==== logic/nmc_regs.sv ====
// Numeric move command register bank with move launch and alarm logic
`timescale 1ns/1ps

module nmc_regs #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register write port, one word per strobe
  input wire logic i_wr_valid,
  input wire logic [WORD_W-1:0] i_wr_addr,
  input wire logic [WORD_W-1:0] i_wr_data,
  input wire logic i_wr_last,
  // Register read port
  input wire logic i_rd_valid,
  input wire logic [WORD_W-1:0] i_rd_addr,
  output logic [WORD_W-1:0] o_rd_data,
  output logic o_rd_ack,
  // Device parameters and motion feedback
  input wire logic [31:0] i_max_speed,
  input wire logic [15:0] i_max_accel,
  input wire logic [31:0] i_default_speed,
  input wire logic [15:0] i_default_accel,
  input wire logic [31:0] i_current_position,
  input wire logic i_move_done,
  // Move command
  output logic o_move_start,
  output logic o_move_alarm,
  output logic [31:0] o_move_target,
  output logic [31:0] o_move_band,
  output logic [31:0] o_move_speed,
  output logic [15:0] o_move_accel,
  output logic [15:0] o_push_limit,
  output logic o_push_mode,
  output logic o_push_reverse,
  output logic [1:0] o_gain_set,
  output nmc_pkg::nmc_prof_e o_accel_profile,
  output logic [1:0] o_vib_set
);
  import nmc_pkg::*;

  //--------------------------------------------------
  // State
  //--------------------------------------------------
  typedef struct packed {
    // Programmed registers
    logic [31:0] target_position;
    logic [31:0] position_band;
    logic [31:0] move_speed;
    logic [15:0] accel_decel;
    logic [15:0] push_current_limit;
    logic [15:0] motion_control_flags;

    // Written since the last finished move
    logic band_wr;
    logic speed_wr;
    logic accel_wr;

    // Query tracking
    logic trig;
    logic go;

    // Read answer
    logic [15:0] rd_data;
    logic rd_ack;

    // Issued move
    logic start;
    logic alarm;
    logic [31:0] m_target;
    logic [31:0] m_band;
    logic [31:0] m_speed;
    logic [15:0] m_accel;
    logic [15:0] m_push;
    logic push_mode;
    logic push_rev;
    logic [1:0] gain;
    nmc_prof_e prof;
    logic [1:0] vib;
  } nmc_state_s;

  nmc_state_s s;
  nmc_state_s next_s;

  //--------------------------------------------------
  // Next state
  //--------------------------------------------------
  always_comb begin
    logic wr_trig;
    logic [31:0] eff_speed;
    logic [15:0] eff_accel;
    logic [31:0] base;
    logic push;
    logic speed_bad;
    logic accel_bad;
    logic prof_bad;
    wr_trig = 1'b0;
    eff_speed = 32'h0;
    eff_accel = 16'h0;
    base = 32'h0;
    push = 1'b0;
    speed_bad = 1'b0;
    accel_bad = 1'b0;
    prof_bad = 1'b0;
    next_s = s;
    next_s.start = 1'b0;
    next_s.alarm = 1'b0;
    next_s.rd_ack = 1'b0;
    next_s.go = 1'b0;
    //--------------------------------------------------
    // Restore after a move
    //--------------------------------------------------
    // Flags fall back to default once a move finishes
    if (i_move_done) begin
      next_s.motion_control_flags = NMC_RST_FLAGS;
      next_s.band_wr = 1'b0;
      next_s.speed_wr = 1'b0;
      next_s.accel_wr = 1'b0;
    end
    //--------------------------------------------------
    // Register writes
    //--------------------------------------------------
    // Word writes; a write in the same cycle beats the restore
    if (i_wr_valid) begin
      unique case (i_wr_addr)
        NMC_ADDR_TARGET_HI: begin
          next_s.target_position[31:16] = i_wr_data;
        end
        NMC_ADDR_TARGET_LO: begin
          next_s.target_position[15:0] = i_wr_data;
          wr_trig = 1'b1;
        end
        NMC_ADDR_BAND_HI: begin
          next_s.position_band[31:16] = i_wr_data;
          next_s.band_wr = 1'b1;
        end
        NMC_ADDR_BAND_LO: begin
          next_s.position_band[15:0] = i_wr_data;
          next_s.band_wr = 1'b1;
        end
        NMC_ADDR_SPEED_HI: begin
          next_s.move_speed[31:16] = i_wr_data;
          next_s.speed_wr = 1'b1;
        end
        NMC_ADDR_SPEED_LO: begin
          next_s.move_speed[15:0] = i_wr_data;
          next_s.speed_wr = 1'b1;
          wr_trig = 1'b1;
        end
        NMC_ADDR_ACCEL: begin
          next_s.accel_decel = i_wr_data;
          next_s.accel_wr = 1'b1;
          wr_trig = 1'b1;
        end
        NMC_ADDR_PUSH: begin
          next_s.push_current_limit = i_wr_data;
          wr_trig = 1'b1;
        end
        NMC_ADDR_FLAGS: begin
          // Unassigned bits are never stored
          next_s.motion_control_flags = i_wr_data & NMC_FLAGS_MASK;
        end
        default: begin
        end
      endcase
      //--------------------------------------------------
      // Query end
      //--------------------------------------------------
      // Launch once the whole query has landed, so a trigger word
      // early in the query still sees the later words of that query
      if (i_wr_last) begin
        next_s.go = s.trig | wr_trig;
        next_s.trig = 1'b0;
      end else begin
        next_s.trig = s.trig | wr_trig;
      end
    end
    //--------------------------------------------------
    // Move launch
    //--------------------------------------------------
    if (s.go) begin
      eff_speed = s.speed_wr ? s.move_speed : i_default_speed;
      eff_accel = s.accel_wr ? s.accel_decel : i_default_accel;
      push = s.motion_control_flags[NMC_F_PUSH];
      // Relative moves add length units, never pulses
      base = push ? i_current_position : s.m_target;
      // Out-of-range values alarm, but the move is still issued
      speed_bad = (eff_speed > i_max_speed) ||
        (eff_speed < NMC_SPEED_MIN) || (eff_speed > NMC_SPEED_MAX);
      accel_bad = (eff_accel > i_max_accel) ||
        (eff_accel < NMC_ACCEL_MIN) || (eff_accel > NMC_ACCEL_MAX);
      prof_bad = (s.motion_control_flags[NMC_F_PROF +: 2] == NMC_PROF_BAD);
      next_s.start = 1'b1;
      next_s.alarm = speed_bad | accel_bad | prof_bad;
      next_s.m_target = s.motion_control_flags[NMC_F_INC] ?
        base + s.target_position : s.target_position;
      next_s.m_band = s.band_wr ? s.position_band : NMC_BAND_DEFAULT;
      next_s.m_speed = eff_speed;
      next_s.m_accel = eff_accel;
      next_s.m_push = s.push_current_limit;
      next_s.push_mode = push;
      next_s.push_rev = push & s.motion_control_flags[NMC_F_DIR];
      next_s.gain = s.motion_control_flags[NMC_F_GAIN +: 2];
      next_s.prof = nmc_prof_e'(s.motion_control_flags[NMC_F_PROF +: 2]);
      next_s.vib = s.motion_control_flags[NMC_F_VIB +: 2];
    end
    //--------------------------------------------------
    // Read back
    //--------------------------------------------------
    // Answer one cycle later; data holds until the next read
    if (i_rd_valid) begin
      next_s.rd_ack = 1'b1;
      unique case (i_rd_addr)
        NMC_ADDR_TARGET_HI: next_s.rd_data = s.target_position[31:16];
        NMC_ADDR_TARGET_LO: next_s.rd_data = s.target_position[15:0];
        NMC_ADDR_BAND_HI: next_s.rd_data = s.position_band[31:16];
        NMC_ADDR_BAND_LO: next_s.rd_data = s.position_band[15:0];
        NMC_ADDR_SPEED_HI: next_s.rd_data = s.move_speed[31:16];
        NMC_ADDR_SPEED_LO: next_s.rd_data = s.move_speed[15:0];
        NMC_ADDR_ACCEL: next_s.rd_data = s.accel_decel;
        NMC_ADDR_PUSH: next_s.rd_data = s.push_current_limit;
        NMC_ADDR_FLAGS: next_s.rd_data = s.motion_control_flags;
        // Unmapped words read as zero
        default: next_s.rd_data = 16'h0000;
      endcase
    end
  end

  //--------------------------------------------------
  // State register
  //--------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s.band_wr <= 1'b0;
      s.speed_wr <= 1'b0;
      s.accel_wr <= 1'b0;
      s.trig <= 1'b0;
      s.go <= 1'b0;
      s.rd_data <= 16'h0000;
      s.rd_ack <= 1'b0;
      s.start <= 1'b0;
      s.alarm <= 1'b0;
      s.m_target <= NMC_RST_TARGET;
      s.m_speed <= 32'h0000_0000;
      s.m_accel <= 16'h0000;
      s.m_push <= 16'h0000;
      s.push_mode <= 1'b0;
      s.push_rev <= 1'b0;
      s.gain <= 2'h0;
      s.vib <= 2'h0;
      s.target_position <= NMC_RST_TARGET;
      s.position_band <= NMC_BAND_DEFAULT;
      s.move_speed <= NMC_SPEED_MIN;
      s.accel_decel <= NMC_ACCEL_MIN;
      s.push_current_limit <= NMC_RST_PUSH;
      s.motion_control_flags <= NMC_RST_FLAGS;
      s.m_band <= NMC_BAND_DEFAULT;
      s.prof <= NMC_PROF_TRAP;
    end else begin
      s <= next_s;
    end
  end

  //--------------------------------------------------
  // Outputs, each straight from the state register
  //--------------------------------------------------
  assign o_rd_data = s.rd_data;
  assign o_rd_ack = s.rd_ack;
  assign o_move_start = s.start;
  assign o_move_alarm = s.alarm;
  assign o_move_target = s.m_target;
  assign o_move_band = s.m_band;
  assign o_move_speed = s.m_speed;
  assign o_move_accel = s.m_accel;
  assign o_push_limit = s.m_push;
  assign o_push_mode = s.push_mode;
  assign o_push_reverse = s.push_rev;
  assign o_gain_set = s.gain;
  assign o_accel_profile = s.prof;
  assign o_vib_set = s.vib;
endmodule

// ==== testbench/nmc_master_model.sv ====
// Bus master model issuing register write queries and reads
`timescale 1ns/1ps
module nmc_master_model (
  // Clock and read answer
  input wire logic i_clock,
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_ack,
  // Requests
  output logic o_wr_valid = 1'b0,
  output logic [15:0] o_wr_addr = 16'h0000,
  output logic [15:0] o_wr_data = 16'h0000,
  output logic o_wr_last = 1'b0,
  output logic o_rd_valid = 1'b0,
  output logic [15:0] o_rd_addr = 16'h0000
);
  task put(input logic [15:0] a, input logic [15:0] d, input logic l);
    @(posedge i_clock);
    o_wr_valid <= 1'b1;
    o_wr_addr <= a;
    o_wr_data <= d;
    o_wr_last <= l;
  endtask
  task rel();
    @(posedge i_clock);
    o_wr_valid <= 1'b0;
    o_wr_last <= 1'b0;
    o_wr_addr <= ~o_wr_addr;
    o_wr_data <= ~o_wr_data;
  endtask
  task get(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_rd_valid <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_clock);
    o_rd_valid <= 1'b0;
    o_rd_addr <= ~a;
    @(posedge i_clock);
    d = i_rd_ack ? i_rd_data : 16'hdead;
  endtask
endmodule

// ==== testbench/nmc_regs_chk.sv ====
// Assertion checker for the move command register bank
`timescale 1ns/1ps
module nmc_regs_chk
  import nmc_pkg::*;
#(
  parameter int WORD_W = 16
) (
  // Clock, reset and requests
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wr_valid,
  input wire logic [WORD_W-1:0] i_wr_addr,
  input wire logic i_wr_last,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_max_speed,
  input wire logic [15:0] i_max_accel,
  // Answers
  input wire logic o_rd_ack,
  input wire logic o_move_start,
  input wire logic o_move_alarm,
  input wire logic [31:0] o_move_target,
  input wire logic [31:0] o_move_speed,
  input wire logic [15:0] o_move_accel,
  input wire logic o_push_mode,
  input wire logic o_push_reverse,
  input wire logic [1:0] o_accel_profile
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  rd_ack_a: assert property (i_rd_valid |=> o_rd_ack) else $error("read ack missing");
  no_ack_a: assert property (!i_rd_valid |=> !o_rd_ack) else $error("stray read ack");
  speed_go_a: assert property (i_wr_valid && i_wr_last &&
    i_wr_addr == NMC_ADDR_SPEED_LO |-> ##2 o_move_start)
    else $error("speed write did not start");
  accel_go_a: assert property (i_wr_valid && i_wr_last &&
    i_wr_addr == NMC_ADDR_ACCEL |-> ##2 o_move_start)
    else $error("accel write did not start");
  alarm_start_a: assert property (o_move_alarm |-> o_move_start) else $error("lone alarm");
  speed_max_a: assert property (o_move_start &&
    o_move_speed > i_max_speed |-> o_move_alarm)
    else $error("speed over max not alarmed");
  accel_max_a: assert property (o_move_start &&
    o_move_accel > i_max_accel |-> o_move_alarm)
    else $error("accel over max not alarmed");
  bad_prof_a: assert property (o_move_start &&
    o_accel_profile == NMC_PROF_BAD |-> o_move_alarm)
    else $error("profile 11 not alarmed");
  dir_push_a: assert property (o_push_reverse |-> o_push_mode) else $error("dir without push");
  hold_move_a: assert property (!o_move_start |->
    $stable(o_move_target) && $stable(o_move_speed))
    else $error("move outputs changed without start");
endmodule
bind nmc_regs nmc_regs_chk #(.WORD_W(WORD_W)) nmc_regs_chk_i (.i_clock, .i_rst_b, .i_wr_valid,
  .i_wr_addr, .i_wr_last, .i_rd_valid, .i_max_speed, .i_max_accel, .o_rd_ack, .o_move_start,
  .o_move_alarm, .o_move_target, .o_move_speed, .o_move_accel, .o_push_mode, .o_push_reverse,
  .o_accel_profile);

// ==== testbench/test_numeric_move_command_regs.sv ====
// Self-checking bench for the move command register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s expected %h seen %h", n, e, a); end end
module test_numeric_move_command_regs;
  import nmc_pkg::*;
  logic i_clock = 0, i_rst_b = 0, i_move_done = 0, i_wr_valid, i_wr_last, i_rd_valid;
  logic [15:0] i_wr_addr, i_wr_data, i_rd_addr, o_rd_data, o_move_accel, o_push_limit;
  logic [31:0] i_max_speed = 32'h0000_2710, i_default_speed = 32'h0000_1f40;
  logic [15:0] i_max_accel = 16'h0064, i_default_accel = 16'h001e;
  logic [31:0] i_current_position = 32'h0000_0000, o_move_target, o_move_band, o_move_speed;
  logic o_rd_ack, o_move_start, o_move_alarm, o_push_mode, o_push_reverse;
  logic [1:0] o_gain_set, o_vib_set;
  nmc_prof_e o_accel_profile;
  int err_count = 0, checks_done = 0;
  int starts = 0;
  logic [15:0] d;
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (o_move_start === 1'b1) starts++;
  end
  nmc_regs nmc_regs_i (.i_clock, .i_rst_b, .i_wr_valid, .i_wr_addr, .i_wr_data, .i_wr_last,
    .i_rd_valid, .i_rd_addr, .o_rd_data, .o_rd_ack, .i_max_speed, .i_max_accel, .i_default_speed,
    .i_default_accel, .i_current_position, .i_move_done, .o_move_start, .o_move_alarm,
    .o_move_target, .o_move_band, .o_move_speed, .o_move_accel, .o_push_limit, .o_push_mode,
    .o_push_reverse, .o_gain_set, .o_accel_profile, .o_vib_set);
  nmc_master_model nmc_master_model_i (.i_clock, .i_rd_data(o_rd_data), .i_rd_ack(o_rd_ack),
    .o_wr_valid(i_wr_valid), .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data),
    .o_wr_last(i_wr_last), .o_rd_valid(i_rd_valid), .o_rd_addr(i_rd_addr));
  task put(input logic [15:0] a, input logic [15:0] v, input logic l);
    nmc_master_model_i.put(a, v, l);
    if (l) nmc_master_model_i.rel();
  endtask
  task automatic go(input logic al);
    int n = 0;
    while (o_move_start !== 1'b1 && n < 8) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    `CHK("start", 1'b1, o_move_start)
    `CHK("alarm", al, o_move_alarm)
  endtask
  task done();
    @(posedge i_clock);
    i_move_done <= 1'b1;
    @(posedge i_clock);
    i_move_done <= 1'b0;
  endtask
  task t_reset();
    `CHK("band", NMC_BAND_DEFAULT, o_move_band)
    nmc_master_model_i.get(NMC_ADDR_SPEED_LO, d);
    `CHK("speed", 16'h0001, d)
    nmc_master_model_i.get(16'h990a, d);
    `CHK("unmapped", 16'h0000, d)
    $display("reset test done");
  endtask
  task t_target();
    put(NMC_ADDR_TARGET_HI, 16'h0000, 1'b0);
    put(NMC_ADDR_TARGET_LO, 16'h1388, 1'b1);
    go(1'b0);
    `CHK("target", 32'h0000_1388, o_move_target)
    `CHK("dspeed", i_default_speed, o_move_speed)
    `CHK("daccel", i_default_accel, o_move_accel)
    `CHK("dband", NMC_BAND_DEFAULT, o_move_band)
    $display("target test done");
  endtask
  task t_band();
    int n0;
    put(NMC_ADDR_BAND_HI, 16'h0000, 1'b0);
    put(NMC_ADDR_BAND_LO, 16'h0014, 1'b1);
    n0 = starts;
    repeat (4) @(posedge i_clock);
    `CHK("nostart", n0, starts)
    put(NMC_ADDR_TARGET_LO, 16'h1388, 1'b1);
    go(1'b0);
    `CHK("band", 32'h0000_0014, o_move_band)
    `CHK("btarget", 32'h0000_1388, o_move_target)
    $display("band test done");
  endtask
  task t_speed();
    put(NMC_ADDR_SPEED_HI, 16'h0000, 1'b0);
    put(NMC_ADDR_SPEED_LO, 16'h2711, 1'b1);
    go(1'b1);
    put(NMC_ADDR_SPEED_LO, 16'h2710, 1'b1);
    go(1'b0);
    `CHK("speed", 32'h0000_2710, o_move_speed)
    put(NMC_ADDR_ACCEL, 16'h012d, 1'b1);
    go(1'b1);
    `CHK("accel", 16'h012d, o_move_accel)
    done();
    $display("speed test done");
  endtask
  task t_flags();
    put(NMC_ADDR_FLAGS, 16'hffff, 1'b0);
    put(NMC_ADDR_PUSH, 16'h0033, 1'b1);
    go(1'b1);
    `CHK("push", 3'h7, {o_push_mode, o_push_reverse, o_push_limit == 16'h0033})
    `CHK("fields", 6'h3f, {o_gain_set, o_accel_profile, o_vib_set})
    nmc_master_model_i.get(NMC_ADDR_FLAGS, d);
    `CHK("flags", NMC_FLAGS_MASK, d)
    done();
    nmc_master_model_i.get(NMC_ADDR_FLAGS, d);
    `CHK("cleared", NMC_RST_FLAGS, d)
    put(NMC_ADDR_FLAGS, 16'h1054, 1'b0);
    put(NMC_ADDR_PUSH, 16'h0040, 1'b1);
    go(1'b0);
    `CHK("nopush", 2'h0, {o_push_mode, o_push_reverse})
    `CHK("fields2", 6'h15, {o_gain_set, o_accel_profile, o_vib_set})
    done();
    $display("flags test done");
  endtask
  task t_inc();
    put(NMC_ADDR_FLAGS, 16'h20a8, 1'b0);
    put(NMC_ADDR_TARGET_LO, 16'h0064, 1'b1);
    go(1'b0);
    `CHK("inc", 32'h0000_13ec, o_move_target)
    `CHK("fields3", 6'h2a, {o_gain_set, o_accel_profile, o_vib_set})
    done();
    i_current_position <= 32'h0000_1000;
    put(NMC_ADDR_FLAGS, 16'h000a, 1'b0);
    put(NMC_ADDR_TARGET_LO, 16'h0064, 1'b1);
    go(1'b0);
    `CHK("pinc", 32'h0000_1064, o_move_target)
    $display("incremental test done");
  endtask
  task finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_reset();
    t_target();
    t_band();
    t_speed();
    t_flags();
    t_inc();
    finish_test();
  end
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
endmodule
